//--- src/pwm_engine_pkg.sv
// Shared constants, carriers and state layout of the grayscale PWM engine
package pwm_engine_pkg;

    // ==========================================================
    // Widths and counts
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CHANNELS = 16;
    localparam int GRAY_W = 12;
    localparam int SEG_BITS = 5;
    localparam int OFFSET_BITS = 7;
    localparam int ONTIME_W = 8;
    localparam logic [GRAY_W-1:0] COUNTER_ZERO = 12'h000;
    localparam logic [GRAY_W-1:0] COUNTER_ONE = 12'h001;
    localparam logic [GRAY_W-1:0] COUNTER_LAST = 12'hFFF;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [ADDR_W-1:0] CONTROL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STROBE_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
    localparam logic [1:0] GRAY_BANK = 2'h1;
    localparam logic [1:0] ACTIVE_BANK = 2'h2;

    // CONTROL fields
    localparam int BLANK_BIT = 0;
    localparam int SPECTRUM_BIT = 1;
    localparam int TIMING_RESET_BIT = 2;
    localparam int AUTO_REPEAT_BIT = 3;
    localparam logic BLANK_RESET = 1'b1;

    // STATUS fields
    localparam int STATUS_COUNTER_LSB = 0;
    localparam int STATUS_PHASE_LSB = 12;
    localparam int STATUS_PENDING_BIT = 14;
    localparam int STATUS_OUTPUTS_LSB = 16;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        PHASE_HELD = 2'b00,
        PHASE_RUN = 2'b01,
        PHASE_DONE = 2'b10
    } phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writeData;
        logic writeStrobe;
        logic readStrobe;
    } reg_request_t;

    typedef struct packed {
        logic blank;
        logic spectrumModeSelect;
        logic timingResetEnable;
        logic autoRepeatEnable;
        phase_t phase;
        logic [GRAY_W-1:0] counter;
        logic gsclkPrev;
        logic refreshPending;
        logic [CHANNELS-1:0][GRAY_W-1:0] firstLatch;
        logic [CHANNELS-1:0][GRAY_W-1:0] secondLatch;
        logic [CHANNELS-1:0] sinkOutputChannel;
        logic [DATA_W-1:0] readData;
    } engine_state_t;

endpackage

//--- src/gray_level_compare.sv
// Per-channel on/off decision for conventional and segmented PWM
`timescale 1ns/1ps
module gray_level_compare
    import pwm_engine_pkg::*;
(
    input wire logic [GRAY_W-1:0] grayLevel,
    input wire logic [GRAY_W-1:0] counter,
    input wire logic running,
    input wire logic spectrumModeSelect,
    output logic channelOn
);

    logic [GRAY_W-1:0] position;
    logic [SEG_BITS-1:0] segment;
    logic [SEG_BITS-1:0] rank;
    logic [OFFSET_BITS-1:0] offset;
    logic [ONTIME_W-1:0] onTime;
    logic counted;

    // ==========================================================
    // Segment decode
    // Counter value c covers the clock after the c-th edge, so position c-1 is used
    assign position = counter - COUNTER_ONE;
    assign segment = position[GRAY_W-1:OFFSET_BITS];
    assign offset = position[OFFSET_BITS-1:0];
    assign counted = running && (counter != COUNTER_ZERO);

    // The fill order 1,17,9,25,... is the bit reversal of the segment index
    always_comb begin
        for (int b = 0; b < SEG_BITS; b++) begin
            rank[b] = segment[SEG_BITS-1-b];
        end
    end

    // Each multiple of 32 adds a clock everywhere, remainder extends low ranks
    assign onTime = {1'b0, grayLevel[GRAY_W-1:SEG_BITS]} + {{(ONTIME_W-1){1'b0}}, (rank < grayLevel[SEG_BITS-1:0])};

    // ==========================================================
    // Decision
    always_comb begin
        if (spectrumModeSelect) begin
            channelOn = counted && ({1'b0, offset} < onTime);
        end else begin
            channelOn = counted && (counter <= grayLevel);
        end
    end

endmodule

//--- src/grayscale_pwm_engine.sv
// Grayscale PWM engine: register port, gray latches, shared counter and 16 sink outputs
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps

module grayscale_pwm_engine
    import pwm_engine_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic grayscaleReferenceClock,
    input wire reg_request_t busRequest,
    output logic [DATA_W-1:0] readData,
    output logic [CHANNELS-1:0] sinkOutputChannel
);

    engine_state_t state;
    engine_state_t next_state;

    logic [CHANNELS-1:0] channelOn;
    logic gsclkRise;
    logic controlWrite;
    logic strobeWrite;
    logic grayWrite;
    logic wordAligned;
    logic [1:0] bank;
    logic [3:0] channelIndex;
    logic restart;
    logic transfer;
    logic periodEnd;

    // ==========================================================
    // Per-channel comparators
    // Outputs are registered from these, so a sink follows the counter by one system clock
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : gen_channel
            gray_level_compare compare (
                .grayLevel(state.secondLatch[ch]),
                .counter(state.counter),
                .running(state.phase == PHASE_RUN),
                .spectrumModeSelect(state.spectrumModeSelect),
                .channelOn(channelOn[ch])
            );
        end
    endgenerate

    // ==========================================================
    // Register port decode
    assign wordAligned = (busRequest.address[1:0] == 2'b00);
    assign bank = busRequest.address[ADDR_W-1:ADDR_W-2];
    assign channelIndex = busRequest.address[5:2];
    assign controlWrite = busRequest.writeStrobe && (busRequest.address == CONTROL_ADDR);
    assign strobeWrite = busRequest.writeStrobe && (busRequest.address == STROBE_ADDR);
    assign grayWrite = busRequest.writeStrobe && wordAligned && (bank == GRAY_BANK);

    // Reference clock is a synchronous input; an edge is a low-to-high step between samples
    assign gsclkRise = grayscaleReferenceClock && !state.gsclkPrev;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_state = state;
        restart = 1'b0;
        transfer = 1'b0;
        periodEnd = 1'b0;
        next_state.gsclkPrev = grayscaleReferenceClock;

        // Control bits take effect at once
        if (controlWrite) begin
            next_state.blank = busRequest.writeData[BLANK_BIT];
            next_state.spectrumModeSelect = busRequest.writeData[SPECTRUM_BIT];
            next_state.timingResetEnable = busRequest.writeData[TIMING_RESET_BIT];
            next_state.autoRepeatEnable = busRequest.writeData[AUTO_REPEAT_BIT];
            // Setting blank uploads waiting gray levels immediately
            if (busRequest.writeData[BLANK_BIT]) begin
                transfer = 1'b1;
            end
        end

        // First latch takes new gray levels at any time
        if (grayWrite) begin
            next_state.firstLatch[channelIndex] = busRequest.writeData[GRAY_W-1:0];
        end

        // Latch strobe
        if (strobeWrite) begin
            if (state.timingResetEnable) begin
                restart = 1'b1;
                transfer = 1'b1;
            end else if (state.blank) begin
                transfer = 1'b1;
            end else begin
                // Running display keeps its levels until the period ends
                next_state.refreshPending = 1'b1;
            end
        end

        // Counter sequencing
        if (next_state.blank) begin
            next_state.counter = COUNTER_ZERO;
            next_state.phase = PHASE_HELD;
        end else if (restart) begin
            // Same effect as a blank pulse; the edge of this cycle is not counted
            next_state.counter = COUNTER_ZERO;
            next_state.phase = PHASE_RUN;
        end else begin
            case (state.phase)
                PHASE_HELD: begin
                    // Blank just cleared: arm, the next edge is the first of the period
                    next_state.phase = PHASE_RUN;
                    next_state.counter = COUNTER_ZERO;
                end
                PHASE_RUN: begin
                    if (gsclkRise) begin
                        if (state.counter == COUNTER_LAST) begin
                            // 4096th edge closes the period
                            periodEnd = 1'b1;
                            next_state.counter = COUNTER_ZERO;
                            if (state.autoRepeatEnable) begin
                                next_state.phase = PHASE_RUN;
                            end else begin
                                next_state.phase = PHASE_DONE;
                            end
                        end else begin
                            next_state.counter = state.counter + COUNTER_ONE;
                        end
                    end
                end
                PHASE_DONE: begin
                    // Counter rests until blank or a timing-reset strobe restarts it
                    next_state.counter = COUNTER_ZERO;
                end
                default: begin
                    next_state.phase = PHASE_HELD;
                    next_state.counter = COUNTER_ZERO;
                end
            endcase
        end

        // Deferred refresh lands on the period boundary
        if (periodEnd && state.refreshPending) begin
            transfer = 1'b1;
        end

        if (transfer) begin
            next_state.secondLatch = next_state.firstLatch;
            next_state.refreshPending = 1'b0;
        end

        // Sink drive
        if (next_state.blank || restart || periodEnd) begin
            next_state.sinkOutputChannel = '0;
        end else begin
            // On-time sums to gray level clocks over the period in either mode
            next_state.sinkOutputChannel = channelOn;
        end

        // Read data stand only in the cycle after the read strobe
        next_state.readData = '0;
        if (busRequest.readStrobe && wordAligned) begin
            if (busRequest.address == CONTROL_ADDR) begin
                next_state.readData[BLANK_BIT] = state.blank;
                next_state.readData[SPECTRUM_BIT] = state.spectrumModeSelect;
                next_state.readData[TIMING_RESET_BIT] = state.timingResetEnable;
                next_state.readData[AUTO_REPEAT_BIT] = state.autoRepeatEnable;
            end else if (busRequest.address == STATUS_ADDR) begin
                next_state.readData[STATUS_COUNTER_LSB +: GRAY_W] = state.counter;
                next_state.readData[STATUS_PHASE_LSB +: 2] = state.phase;
                next_state.readData[STATUS_PENDING_BIT] = state.refreshPending;
                next_state.readData[STATUS_OUTPUTS_LSB +: CHANNELS] = state.sinkOutputChannel;
            end else if (bank == GRAY_BANK) begin
                next_state.readData[GRAY_W-1:0] = state.firstLatch[channelIndex];
            end else if (bank == ACTIVE_BANK) begin
                next_state.readData[GRAY_W-1:0] = state.secondLatch[channelIndex];
            end
        end
    end

    // ==========================================================
    // State register
    // Gray latches clear to zero so simulation never sees unknowns; software must still load them
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
            state.blank <= BLANK_RESET;
            state.phase <= PHASE_HELD;
        end else begin
            state <= next_state;
        end
    end

    assign readData = state.readData;
    assign sinkOutputChannel = state.sinkOutputChannel;

endmodule

//--- testbench/grayscale_pwm_engine_properties.sv
// Port checker for the grayscale PWM engine
`timescale 1ns/1ps
module grayscale_pwm_engine_checker
    import pwm_engine_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic grayscaleReferenceClock,
    input wire reg_request_t busRequest,
    input wire logic [DATA_W-1:0] readData,
    input wire logic [CHANNELS-1:0] sinkOutputChannel
);
    // ==========
    // Helper state
    logic prevRef;
    logic riseDly;
    logic riseDly2;
    logic writeDly;
    logic blankShadow;
    logic [3:0] ctrlWritten;
    logic ctrlWrite;
    assign ctrlWrite = busRequest.writeStrobe && busRequest.address == CONTROL_ADDR;
    always_ff @(posedge clk) begin
        prevRef <= grayscaleReferenceClock;
        riseDly <= grayscaleReferenceClock & ~prevRef;
        riseDly2 <= riseDly;
        writeDly <= busRequest.writeStrobe;
        if (ctrlWrite)
            ctrlWritten <= busRequest.writeData[3:0];
        if (reset)
            blankShadow <= BLANK_RESET;
        else if (ctrlWrite)
            blankShadow <= busRequest.writeData[BLANK_BIT];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========
    // Properties
    a_blank_dark: assert property (blankShadow && $past(blankShadow) |-> sinkOutputChannel == '0)
        else $error("sink lit while blanked");
    a_reset_clears: assert property ($fell(reset) |-> sinkOutputChannel == '0 && readData == '0)
        else $error("outputs not clear after reset");
    a_read_one_cycle: assert property (!$past(busRequest.readStrobe) |-> readData == '0)
        else $error("read data outside its cycle");
    a_control_readback: assert property (ctrlWrite ##1 busRequest.readStrobe && busRequest.address == CONTROL_ADDR
        |=> readData[3:0] == ctrlWritten)
        else $error("control bits not read back");
    a_strobe_reads_zero: assert property (busRequest.readStrobe && busRequest.address == STROBE_ADDR |=> readData == '0)
        else $error("strobe register read not zero");
    a_unmapped_zero: assert property (busRequest.readStrobe && busRequest.address == 8'hFC |=> readData == '0)
        else $error("unmapped read not zero");
    a_sink_change_cause: assert property ($changed(sinkOutputChannel) |-> riseDly || riseDly2 || writeDly)
        else $error("sinks changed without a cause");
    a_turn_on_lag: assert property (|(sinkOutputChannel & ~$past(sinkOutputChannel)) |-> riseDly2)
        else $error("sink turned on off the clock rise");
endmodule
bind grayscale_pwm_engine grayscale_pwm_engine_checker checker_i (.clk(clk), .reset(reset),
    .grayscaleReferenceClock(grayscaleReferenceClock), .busRequest(busRequest), .readData(readData),
    .sinkOutputChannel(sinkOutputChannel));

//--- testbench/gray_clock_source.sv
// Reference clock source for the engine, idle low between bursts
`timescale 1ns/1ps
module gray_clock_source (
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    output logic refClock,
    output int riseCount
);
    // ==========
    // Toggles every cycle: high and low each last one system clock
    always_ff @(posedge clk) begin
        if (reset || !go)
            refClock <= 1'b0;
        else
            refClock <= ~refClock;
        if (reset)
            riseCount <= 0;
        else if (go && !refClock)
            riseCount <= riseCount + 1;
    end
endmodule

//--- testbench/grayscale_pwm_engine_bench.sv
// Self-checking bench for the grayscale PWM engine
`timescale 1ns/1ps
module grayscale_pwm_engine_bench
    import pwm_engine_pkg::*;
;
    localparam int LVL[8] = '{0, 1, 2, 31, 32, 33, 4063, 4095};
    localparam int ES_PULSES[8] = '{0, 1, 2, 31, 32, 32, 32, 1};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic go = 1'b0;
    logic measure = 1'b0;
    logic refClock;
    int riseCount;
    reg_request_t busRequest = '0;
    logic [DATA_W-1:0] readData;
    logic [DATA_W-1:0] value;
    logic [CHANNELS-1:0] sinkOutputChannel;
    logic [CHANNELS-1:0] prevSink = '0;
    int onCount[8];
    int pulses[8];
    int miscompares = 0;
    int totalChecks = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    gray_clock_source source (.clk(clk), .reset(reset), .go(go), .refClock(refClock), .riseCount(riseCount));
    grayscale_pwm_engine DUT (.clk(clk), .reset(reset), .grayscaleReferenceClock(refClock),
        .busRequest(busRequest), .readData(readData), .sinkOutputChannel(sinkOutputChannel));

    // ==========
    // Watchdog and on-time meter; sinks sampled at each rise show the previous count
    always @(posedge clk) begin
        cycles++;
        if (cycles == 50000) begin
            miscompares++;
            wrap_up();
        end
    end
    always @(posedge clk) begin
        if (measure && refClock) begin
            for (int ch = 0; ch < 8; ch++) begin
                onCount[ch] += sinkOutputChannel[ch];
                pulses[ch] += sinkOutputChannel[ch] && !prevSink[ch];
            end
            prevSink <= sinkOutputChannel;
        end
    end

    // ==========
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        totalChecks++;
        if (seen !== expected) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", name, expected, seen);
        end
    endtask
    task automatic wr(input logic [7:0] address, input logic [31:0] data);
        @(posedge clk);
        busRequest <= '{address, data, 1'b1, 1'b0};
    endtask
    task automatic rd(input logic [7:0] address);
        @(posedge clk);
        busRequest <= '{address, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        busRequest <= '0;
        #1 value = readData;
    endtask
    task automatic run_rises(input int count);
        int target;
        target = riseCount + count;
        @(posedge clk);
        busRequest <= '0;
        go <= 1'b1;
        while (riseCount < target) @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic measure_run(input int count, input int periods, input logic segmented);
        onCount = '{default: 0};
        pulses = '{default: 0};
        measure <= 1'b1;
        run_rises(count);
        measure <= 1'b0;
        for (int ch = 0; ch < 8; ch++) begin
            check("on time", onCount[ch], periods * LVL[ch]);
            check("pulse count", pulses[ch], periods * (segmented ? ES_PULSES[ch] : (LVL[ch] > 0)));
        end
    endtask
    task automatic wrap_up();
        if (miscompares == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(CONTROL_ADDR);
        check("control after reset", value, 32'h1);
        rd(8'hFC);
        rd(STROBE_ADDR);
        rd(STATUS_ADDR);
        check("status after reset", value & 32'hFFFF0FFF, 32'h0);
        for (int ch = 0; ch < CHANNELS; ch++)
            wr(8'h40 + 8'(4 * ch), ch < 8 ? LVL[ch] : 0);
        wr(STROBE_ADDR, 32'h1);
        wr(CONTROL_ADDR, 32'h0);
        rd(CONTROL_ADDR);
        rd(8'h98);
        check("active latch", value, 32'(LVL[6]));
        measure_run(4096, 1, 1'b0);
        run_rises(4);
        rd(STATUS_ADDR);
        check("status after single period", value, 32'h2000);
        wr(CONTROL_ADDR, 32'h1);
        wr(CONTROL_ADDR, 32'hA);
        rd(CONTROL_ADDR);
        measure_run(8192, 2, 1'b1);
        wr(CONTROL_ADDR, 32'h4);
        run_rises(10);
        wr(STROBE_ADDR, 32'h1);
        rd(STATUS_ADDR);
        check("status at timing reset", value & 32'hFFFF0FFF, 32'h0);
        run_rises(3);
        rd(STATUS_ADDR);
        check("status after restart", value, 32'h00F8_1003);
        // A strobe without timing reset during a running period waits for the period boundary
        wr(CONTROL_ADDR, 32'h8);
        wr(8'h40, 32'h5);
        wr(STROBE_ADDR, 32'h1);
        rd(STATUS_ADDR);
        check("refresh pending", value & 32'h4000, 32'h4000);
        rd(8'h80);
        check("active latch held", value, 32'(LVL[0]));
        run_rises(4096);
        rd(8'h80);
        check("active latch refreshed", value, 32'h5);
        wr(CONTROL_ADDR, 32'h1);
        run_rises(5);
        rd(STATUS_ADDR);
        check("status while blanked", value & 32'hFFFF0FFF, 32'h0);
        wrap_up();
    end
endmodule
